// *** design/jump_and_load_decode.sv ***
// Fetch, decode and execute of absolute jump, relative jump and byte load
`default_nettype none
module jump_and_load_decode
  import jld_pkg::*;
#(
  parameter int REG_COUNT = 256
)(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Program memory fetch
  output logic [15:0]      prog_addr,
  output logic             prog_rd,
  input  wire logic [7:0]  prog_data,
  input  wire logic        prog_ack,
  // Flags from the core, read only
  input  wire logic [7:0]  flags,
  // Core register write port
  input  wire logic        core_wr_en,
  input  wire logic [7:0]  core_wr_addr,
  input  wire logic [7:0]  core_wr_data,
  // Register read port
  input  wire logic [7:0]  core_rd_addr,
  output logic [7:0]       core_rd_data,
  // Status pulses
  output logic             instr_done,
  output logic             jump_taken,
  output logic             foreign_op
);
  seq_state_t  state_q, state_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0]  op_q, op_d;
  logic [7:0]  b2_q, b2_d;
  logic [7:0]  b3_q, b3_d;
  logic [3:0]  cnt_q, cnt_d;
  logic        done_q, done_d;
  logic        jump_q, jump_d;
  logic        foreign_q, foreign_d;
  logic [7:0]  rd_q, rd_d;
  logic [7:0]  regs [REG_COUNT];

  logic [1:0]  len;
  logic [3:0]  cyc;
  logic [3:0]  cyc_of_op;
  logic [1:0]  len_of_op;
  logic        cond_true;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [15:0] disp_ext;
  logic [7:0]  pair_even;
  logic [7:0]  pair_odd;

  // Working register address inside the register file
  function automatic logic [7:0] wreg(input logic [3:0] n);
    wreg = {WREG_PAGE, n};
  endfunction

  // Length and cycle count of an opcode byte
  function automatic logic [5:0] shape(input logic [7:0] op);
    logic [1:0] l;
    logic [3:0] c;
    l = LEN_ONE;
    c = CYC_FOREIGN;
    if (op == OP_JP_PAIR) begin
      l = LEN_TWO;
      c = CYC_JP;
    end else if (op[3:0] == NIB_JP_DA) begin
      l = LEN_THREE;
      c = CYC_JP;
    end else if (op[3:0] == NIB_JR) begin
      l = LEN_TWO;
      c = CYC_JR;
    end else if (op[3:0] == NIB_LD_IM || op[3:0] == NIB_LD_R_G || op[3:0] == NIB_LD_G_R ||
                 op == OP_LD_R_IR || op == OP_LD_IR_R) begin
      l = LEN_TWO;
      c = CYC_LD_SHORT;
    end else if (op == OP_LD_G_G || op == OP_LD_G_IG || op == OP_LD_G_IM || op == OP_LD_IG_IM ||
                 op == OP_LD_IG_G || op == OP_LD_R_X || op == OP_LD_X_R) begin
      l = LEN_THREE;
      c = CYC_LD_LONG;
    end
    shape = {l, c};
  endfunction

  assign {len_of_op, cyc_of_op} = shape(prog_data);
  assign {len, cyc} = shape(op_q);

  // Condition selector in the upper nibble of the first byte
  branch_condition_eval u_cond (
    .branch_condition (op_q[7:4]),
    .flags            (flags),
    .taken            (cond_true)
  );

  // Sign-extended displacement, confined to -128..+127
  assign disp_ext  = {{8{b2_q[7]}}, b2_q};
  assign pair_even = {b2_q[7:1], 1'b0};
  assign pair_odd  = {b2_q[7:1], 1'b1};

  // Fetch handshake: request while waiting for an instruction byte
  assign prog_rd    = (state_q == ST_OP) || (state_q == ST_B2) || (state_q == ST_B3);
  assign prog_addr  = pc_q;
  assign instr_done = done_q;
  assign jump_taken = jump_q;
  assign foreign_op = foreign_q;
  assign core_rd_data = rd_q;

  // Sequencer, program counter and execute
  always_comb begin
    state_d   = state_q;
    pc_d      = pc_q;
    op_d      = op_q;
    b2_d      = b2_q;
    b3_d      = b3_q;
    cnt_d     = cnt_q;
    done_d    = 1'b0;
    jump_d    = 1'b0;
    foreign_d = 1'b0;
    wr_en     = 1'b0;
    wr_addr   = BYTE_ZERO;
    wr_data   = BYTE_ZERO;
    rd_d      = regs[core_rd_addr];
    // Saturate so a long fetch stall cannot wrap the count and stretch the instruction
    if (state_q != ST_OP && cnt_q != 4'hF) begin
      cnt_d = cnt_q + 4'h1;
    end
    case (state_q)
      ST_OP: begin
        if (prog_ack) begin
          op_d  = prog_data;
          pc_d  = pc_q + 16'h0001;
          cnt_d = 4'h1;
          if (len_of_op == LEN_ONE) begin
            foreign_d = 1'b1;
            cnt_d     = CNT_RESET;
          end else begin
            state_d = ST_B2;
          end
        end
      end
      ST_B2: begin
        if (prog_ack) begin
          b2_d    = prog_data;
          pc_d    = pc_q + 16'h0001;
          state_d = (len == LEN_THREE) ? ST_B3 : ST_EXEC;
        end
      end
      ST_B3: begin
        if (prog_ack) begin
          b3_d    = prog_data;
          pc_d    = pc_q + 16'h0001;
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        // PC already points past the instruction here
        if (op_q == OP_JP_PAIR) begin
          pc_d   = {regs[pair_even], regs[pair_odd]};
          jump_d = 1'b1;
        end else if (op_q[3:0] == NIB_JP_DA) begin
          if (cond_true) begin
            pc_d   = {b2_q, b3_q};
            jump_d = 1'b1;
          end
        end else if (op_q[3:0] == NIB_JR) begin
          if (cond_true) begin
            pc_d   = pc_q + disp_ext;
            jump_d = 1'b1;
          end
        end else begin
          // Only the destination is written; sources are read only
          wr_en = 1'b1;
          if (op_q[3:0] == NIB_LD_IM) begin
            wr_addr = wreg(op_q[7:4]);
            wr_data = b2_q;
          end else if (op_q[3:0] == NIB_LD_R_G) begin
            wr_addr = wreg(op_q[7:4]);
            wr_data = regs[b2_q];
          end else if (op_q[3:0] == NIB_LD_G_R) begin
            wr_addr = b2_q;
            wr_data = regs[wreg(op_q[7:4])];
          end else begin
            case (op_q)
              OP_LD_R_IR: begin
                wr_addr = wreg(b2_q[7:4]);
                wr_data = regs[regs[wreg(b2_q[3:0])]];
              end
              OP_LD_IR_R: begin
                wr_addr = regs[wreg(b2_q[7:4])];
                wr_data = regs[wreg(b2_q[3:0])];
              end
              OP_LD_G_G: begin
                wr_addr = b3_q;
                wr_data = regs[b2_q];
              end
              OP_LD_G_IG: begin
                wr_addr = b3_q;
                wr_data = regs[regs[b2_q]];
              end
              OP_LD_G_IM: begin
                wr_addr = b2_q;
                wr_data = b3_q;
              end
              OP_LD_IG_IM: begin
                wr_addr = regs[b2_q];
                wr_data = b3_q;
              end
              OP_LD_IG_G: begin
                wr_addr = regs[b3_q];
                wr_data = regs[b2_q];
              end
              OP_LD_R_X: begin
                wr_addr = wreg(b2_q[7:4]);
                wr_data = regs[b3_q + regs[wreg(b2_q[3:0])]];
              end
              OP_LD_X_R: begin
                wr_addr = b3_q + regs[wreg(b2_q[3:0])];
                wr_data = regs[wreg(b2_q[7:4])];
              end
              default: begin
                wr_en = 1'b0;
              end
            endcase
          end
        end
        if (cnt_q >= cyc - 4'h1) begin
          state_d = ST_OP;
          done_d  = 1'b1;
          cnt_d   = CNT_RESET;
        end else begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // Pad out to the documented cycle count
        if (cnt_q >= cyc - 4'h1) begin
          state_d = ST_OP;
          done_d  = 1'b1;
          cnt_d   = CNT_RESET;
        end
      end
      default: begin
        state_d = ST_OP;
        cnt_d   = CNT_RESET;
      end
    endcase
  end

  // Sequencer registers; flags have no write path from here
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q   <= ST_OP;
      pc_q      <= PC_RESET;
      op_q      <= BYTE_ZERO;
      b2_q      <= BYTE_ZERO;
      b3_q      <= BYTE_ZERO;
      cnt_q     <= CNT_RESET;
      done_q    <= 1'b0;
      jump_q    <= 1'b0;
      foreign_q <= 1'b0;
      rd_q      <= BYTE_ZERO;
    end else begin
      state_q   <= state_d;
      pc_q      <= pc_d;
      op_q      <= op_d;
      b2_q      <= b2_d;
      b3_q      <= b3_d;
      cnt_q     <= cnt_d;
      done_q    <= done_d;
      jump_q    <= jump_d;
      foreign_q <= foreign_d;
      rd_q      <= rd_d;
    end
  end

  // Register file; a load wins over a core write in the same cycle
  always_ff @(posedge clk) begin
    if (wr_en) begin
      regs[wr_addr] <= wr_data;
    end else if (core_wr_en) begin
      regs[core_wr_addr] <= core_wr_data;
    end
  end
endmodule // jump_and_load_decode
`default_nettype wire

// *** design/jld_pkg.sv ***
// Shared constants for the jump and byte load decode block
`default_nettype none
package jld_pkg;
  // Full opcodes
  localparam logic [7:0] OP_JP_PAIR  = 8'h30;
  localparam logic [7:0] OP_LD_R_IR  = 8'hC7;
  localparam logic [7:0] OP_LD_IR_R  = 8'hD7;
  localparam logic [7:0] OP_LD_G_G   = 8'hE4;
  localparam logic [7:0] OP_LD_G_IG  = 8'hE5;
  localparam logic [7:0] OP_LD_G_IM  = 8'hE6;
  localparam logic [7:0] OP_LD_IG_IM = 8'hD6;
  localparam logic [7:0] OP_LD_IG_G  = 8'hF5;
  localparam logic [7:0] OP_LD_R_X   = 8'h87;
  localparam logic [7:0] OP_LD_X_R   = 8'h97;
  // Low opcode nibbles of the nibble-coded forms
  localparam logic [3:0] NIB_JP_DA   = 4'hD;
  localparam logic [3:0] NIB_JR      = 4'hB;
  localparam logic [3:0] NIB_LD_IM   = 4'hC;
  localparam logic [3:0] NIB_LD_R_G  = 4'h8;
  localparam logic [3:0] NIB_LD_G_R  = 4'h9;
  // Instruction lengths in bytes
  localparam logic [1:0] LEN_ONE     = 2'h1;
  localparam logic [1:0] LEN_TWO     = 2'h2;
  localparam logic [1:0] LEN_THREE   = 2'h3;
  // Cycle counts per instruction
  localparam logic [3:0] CYC_JP      = 4'h8;
  localparam logic [3:0] CYC_JR      = 4'h6;
  localparam logic [3:0] CYC_LD_SHORT = 4'h4;
  localparam logic [3:0] CYC_LD_LONG = 4'h6;
  localparam logic [3:0] CYC_FOREIGN = 4'h1;
  // Flag bit positions
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  // Branch condition selectors
  localparam logic [3:0] BC_NEVER  = 4'h0;
  localparam logic [3:0] BC_LT     = 4'h1;
  localparam logic [3:0] BC_LE     = 4'h2;
  localparam logic [3:0] BC_ULE    = 4'h3;
  localparam logic [3:0] BC_OV     = 4'h4;
  localparam logic [3:0] BC_MI     = 4'h5;
  localparam logic [3:0] BC_Z      = 4'h6;
  localparam logic [3:0] BC_C      = 4'h7;
  localparam logic [3:0] BC_ALWAYS = 4'h8;
  localparam logic [3:0] BC_GE     = 4'h9;
  localparam logic [3:0] BC_GT     = 4'hA;
  localparam logic [3:0] BC_UGT    = 4'hB;
  localparam logic [3:0] BC_NOV    = 4'hC;
  localparam logic [3:0] BC_PL     = 4'hD;
  localparam logic [3:0] BC_NZ     = 4'hE;
  localparam logic [3:0] BC_NC     = 4'hF;
  // Reset values and working register page
  localparam logic [15:0] PC_RESET   = 16'h0000;
  localparam logic [3:0]  WREG_PAGE  = 4'h0;
  localparam logic [3:0]  CNT_RESET  = 4'h0;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_OP   = 5'b00001,
    ST_B2   = 5'b00010,
    ST_B3   = 5'b00100,
    ST_EXEC = 5'b01000,
    ST_HOLD = 5'b10000
  } seq_state_t;
endpackage
`default_nettype wire

// *** design/branch_condition_eval.sv ***
// Evaluates a branch condition selector against the flag byte
`default_nettype none
module branch_condition_eval
  import jld_pkg::*;
(
  // Selector and flags
  input  wire logic [3:0] branch_condition,
  input  wire logic [7:0] flags,
  // Result
  output logic            taken
);
  logic c;
  logic z;
  logic s;
  logic v;

  // Flag taps
  assign c = flags[FLAG_C];
  assign z = flags[FLAG_Z];
  assign s = flags[FLAG_S];
  assign v = flags[FLAG_V];

  // Condition table
  always_comb begin
    case (branch_condition)
      BC_NEVER:  taken = 1'b0;
      BC_LT:     taken = s ^ v;
      BC_LE:     taken = z | (s ^ v);
      BC_ULE:    taken = c | z;
      BC_OV:     taken = v;
      BC_MI:     taken = s;
      BC_Z:      taken = z;
      BC_C:      taken = c;
      BC_ALWAYS: taken = 1'b1;
      BC_GE:     taken = ~(s ^ v);
      BC_GT:     taken = ~(z | (s ^ v));
      BC_UGT:    taken = ~c & ~z;
      BC_NOV:    taken = ~v;
      BC_PL:     taken = ~s;
      BC_NZ:     taken = ~z;
      BC_NC:     taken = ~c;
      default:   taken = 1'b0;
    endcase
  end
endmodule // branch_condition_eval
`default_nettype wire

// *** bench/prog_mem_model.sv ***
// Program memory model that answers the fetch port
`default_nettype none
module prog_mem_model (
  // Fetch side
  input  wire logic        clk,
  input  wire logic [15:0] prog_addr,
  input  wire logic        prog_rd,
  input  wire logic        stall,
  output logic             prog_ack,
  output logic [7:0]       prog_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [65536];
  logic [7:0] last_q = 8'h5A;
  // Unwritten cells hold a one-byte foreign opcode
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // Answer at once unless stalled; data is scrambled while not answering
  assign prog_ack  = prog_rd & ~stall;
  assign prog_data = prog_ack ? mem[prog_addr] : ~last_q;
  // Last byte handed out
  always @(posedge clk) if (prog_ack) last_q <= prog_data;
endmodule // prog_mem_model
`default_nettype wire

// *** bench/jump_and_load_decode_sva.sv ***
// Port checks for the jump and byte load decode block
`default_nettype none
module jump_and_load_decode_sva
  import jld_pkg::*;
#(
  parameter int REG_COUNT = 256
)(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Fetch and status
  input wire logic [15:0] prog_addr,
  input wire logic        prog_rd,
  input wire logic [7:0]  prog_data,
  input wire logic        prog_ack,
  input wire logic        instr_done,
  input wire logic        jump_taken,
  input wire logic        foreign_op
);
  timeunit 1ns;
  timeprecision 1ns;
  logic take, op_take, op_q, op_d;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Byte takes, and takes of an opcode byte
  assign take    = prog_rd && prog_ack;
  assign op_take = take && (op_q || instr_done);
  // An opcode is due after reset and after each instr_done pulse, not after a foreign opcode
  always_comb begin
    op_d = op_q;
    if (instr_done) op_d = 1'b1;
    if (take) op_d = 1'b0;
    if (!rst_b) op_d = 1'b1;
  end
  always_ff @(posedge clk) op_q <= op_d;
  fetch_step_a: assert property (take |=> prog_addr == $past(prog_addr) + 16'h0001)
    else $error("fetch address did not step");
  fetch_hold_a: assert property (prog_rd && !prog_ack |=> $stable(prog_addr))
    else $error("fetch address moved while waiting");
  jp_min_a: assert property (op_take && prog_data[3:0] == NIB_JP_DA |=> !instr_done [*7])
    else $error("absolute jump ended early");
  jr_min_a: assert property (op_take && prog_data[3:0] == NIB_JR |=> !instr_done [*5])
    else $error("relative jump ended early");
  da_taken_a: assert property (op_take && prog_data == {BC_ALWAYS, NIB_JP_DA} |-> ##[4:40] jump_taken)
    else $error("unconditional direct jump not taken");
  never_jump_a: assert property (op_take && prog_data[7:4] == BC_NEVER |=> !jump_taken until instr_done)
    else $error("jump taken on false condition");
  never_done_a: assert property (op_take && (prog_data == {BC_NEVER, NIB_JR}
    || prog_data == {BC_NEVER, NIB_JP_DA}) |-> ##[6:40] instr_done)
    else $error("skipped jump never finished");
  // Pair jump runs its execute step one byte earlier, so it pads one cycle longer
  taken_done_a: assert property (jump_taken |-> ##[0:5] (prog_rd && instr_done))
    else $error("no fetch after taken jump");
  done_fetch_a: assert property (instr_done |-> prog_rd)
    else $error("instruction end without fetch");
  // Main scenarios
  jump_c: cover property (jump_taken);
  foreign_c: cover property (foreign_op);
  stall_c: cover property (prog_rd && !prog_ack);
endmodule // jump_and_load_decode_sva
bind jump_and_load_decode jump_and_load_decode_sva #(.REG_COUNT(REG_COUNT)) u_jump_and_load_decode_sva (
  .clk(clk), .rst_b(rst_b), .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_data(prog_data),
  .prog_ack(prog_ack), .instr_done(instr_done), .jump_taken(jump_taken), .foreign_op(foreign_op));
`default_nettype wire

// *** bench/test_jump_and_load_decode.sv ***
// Self-checking bench for the jump and byte load decode block
`default_nettype none
module test_jump_and_load_decode;
  timeunit 1ns;
  timeprecision 1ns;
  import jld_pkg::*;
  logic        clk = 1'b0, rst_b = 1'b0, hold = 1'b1, slow = 1'b0, rbit = 1'b0, core_wr_en = 1'b0;
  logic        prog_rd, prog_ack, stall, instr_done, jump_taken, foreign_op;
  logic [15:0] prog_addr, pc;
  logic [7:0]  prog_data, core_rd_data, flags = 8'h00;
  logic [7:0]  core_wr_addr = 8'h00, core_wr_data = 8'h00, core_rd_addr = 8'h00;
  logic [7:0]  m [256];
  logic [31:0] seed = 32'd322;
  logic [15:0] exp_q [$];
  int          cyc_q [$];
  int          errors = 0, tests_run = 0, cnt = -1, tcnt = 0;
  assign stall = hold | (slow & rbit);
  jump_and_load_decode #(.REG_COUNT(256)) u_jump_and_load_decode (.clk(clk), .rst_b(rst_b),
    .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_data(prog_data), .prog_ack(prog_ack), .flags(flags),
    .core_wr_en(core_wr_en), .core_wr_addr(core_wr_addr), .core_wr_data(core_wr_data),
    .core_rd_addr(core_rd_addr), .core_rd_data(core_rd_data), .instr_done(instr_done),
    .jump_taken(jump_taken), .foreign_op(foreign_op));
  prog_mem_model u_prog_mem_model (.clk(clk), .prog_addr(prog_addr), .prog_rd(prog_rd), .stall(stall),
    .prog_ack(prog_ack), .prog_data(prog_data));
  // Clock
  initial forever #10 clk = ~clk;
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Condition table on the flag byte, upper half inverts the lower
  function automatic logic cond(input logic [3:0] cc);
    logic [3:0] f;
    logic r;
    f = flags[7:4];
    case (cc[2:0])
      3'd0: r = 1'b0;
      3'd1: r = f[1] ^ f[0];
      3'd2: r = f[2] | (f[1] ^ f[0]);
      3'd3: r = f[3] | f[2];
      3'd4: r = f[0];
      3'd5: r = f[1];
      3'd6: r = f[2];
      default: r = f[3];
    endcase
    return r ^ cc[3];
  endfunction
  task automatic chk(input logic ok, input string s);
    tests_run++;
    if (ok !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: %s", $time, s);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic put(input logic [7:0] x);
    u_prog_mem_model.mem[pc] = x;
    pc = pc + 16'h0001;
  endtask
  task automatic nxt(input logic [15:0] a, input int c);
    exp_q.push_back(a);
    cyc_q.push_back(c);
    pc = a;
  endtask
  // One byte load of the given kind, with its effect on the model file
  task automatic load(input int kind);
    logic [7:0] a, b, v, ix, op, x, y, dst, val;
    logic [3:0] n, s;
    logic [1:0] len;
    a = 8'h20 + 8'(rnd() & 32'h7F);
    b = 8'h20 + 8'(rnd() & 32'h7F);
    v = 8'(rnd());
    n = 4'(rnd());
    s = 4'(rnd());
    ix = v + m[{WREG_PAGE, s}];
    case (kind)
      0: {op, x, y, len, dst, val} = {OP_LD_G_IM, a, v, 2'd3, a, v};
      1: {op, x, y, len, dst, val} = {n, NIB_LD_IM, v, 8'h00, 2'd2, WREG_PAGE, n, v};
      2: {op, x, y, len, dst, val} = {OP_LD_G_G, a, b, 2'd3, b, m[a]};
      3: {op, x, y, len, dst, val} = {n, NIB_LD_R_G, a, 8'h00, 2'd2, WREG_PAGE, n, m[a]};
      4: {op, x, y, len, dst, val} = {n, NIB_LD_G_R, b, 8'h00, 2'd2, b, m[{WREG_PAGE, n}]};
      5: {op, x, y, len, dst, val} = {OP_LD_G_IG, a, b, 2'd3, b, m[m[a]]};
      6: {op, x, y, len, dst, val} = {OP_LD_IG_IM, b, v, 2'd3, m[b], v};
      7: {op, x, y, len, dst, val} = {OP_LD_IG_G, a, b, 2'd3, m[b], m[a]};
      8: {op, x, y, len, dst, val} = {OP_LD_R_IR, n, s, 8'h00, 2'd2, WREG_PAGE, n, m[m[{WREG_PAGE, s}]]};
      9: {op, x, y, len, dst, val} = {OP_LD_IR_R, n, s, 8'h00, 2'd2, m[{WREG_PAGE, n}], m[{WREG_PAGE, s}]};
      10: {op, x, y, len, dst, val} = {OP_LD_R_X, n, s, v, 2'd3, WREG_PAGE, n, m[ix]};
      default: {op, x, y, len, dst, val} = {OP_LD_X_R, n, s, v, 2'd3, ix, m[{WREG_PAGE, n}]};
    endcase
    put(op);
    put(x);
    if (len == 2'd3) put(y);
    nxt(pc, (len == 2'd3) ? 6 : 4);
    m[dst] = val;
  endtask
  // One program run: fill registers, build the program, execute, read back
  task automatic run(input logic sl);
    logic [15:0] b, t;
    logic [7:0]  d;
    logic        fo;
    hold = 1'b1;
    slow = sl;
    rst_b = 1'b0;
    flags = 8'(rnd());
    repeat (4) @(posedge clk);
    #1 rst_b = 1'b1;
    core_wr_en = 1'b1;
    for (int k = 0; k < 256; k++) begin
      core_wr_addr = 8'(k);
      core_wr_data = 8'(rnd());
      m[k] = core_wr_data;
      @(posedge clk);
      #1;
    end
    core_wr_en = 1'b0;
    pc = 16'h0000;
    for (int k = 0; k < 16; k++) begin
      b = 16'(k) << 12;
      d = 8'(rnd());
      // Always-true selector takes +127; one of the complementary pair 1 and 9 takes -128
      d = (k == 8) ? 8'h7F : (k % 8 == 1) ? 8'h80 : d[7] ? {2'b10, d[5:0]} : d;
      put({4'(k), NIB_JR});
      put(d);
      nxt(cond(4'(k)) ? pc + {{8{d[7]}}, d} : pc, 6);
      t = b + 16'h0600;
      put({4'(k), NIB_JP_DA});
      put(t[15:8]);
      put(t[7:0]);
      nxt(cond(4'(k)) ? t : pc, 8);
      load(k % 12);
      // Last pair jump lands in a long run of foreign bytes, far from the address wrap
      t = (k == 15) ? 16'hFF00 : b + 16'h1000;
      put(OP_LD_G_IM);
      put(8'hE0);
      put(t[15:8]);
      m[8'hE0] = t[15:8];
      nxt(pc, 6);
      put(OP_LD_G_IM);
      put(8'hE1);
      put(t[7:0]);
      m[8'hE1] = t[7:0];
      nxt(pc, 6);
      put(OP_JP_PAIR);
      put(8'hE0);
      nxt(t, 8);
    end
    hold = 1'b0;
    while (exp_q.size() != 0) @(posedge clk);
    fo = 1'b0;
    repeat (40) @(negedge clk) fo = fo | foreign_op;
    chk(fo === 1'b1, "no foreign opcode pulse");
    @(posedge clk);
    #1 hold = 1'b1;
    for (int k = 0; k < 256; k++) begin
      core_rd_addr = 8'(k);
      @(posedge clk);
      #1;
      chk(core_rd_data === m[k], "register contents differ");
    end
    $display("run done, slow=%0d", sl);
  endtask
  // Cycle ceiling and random stall pattern
  always @(posedge clk) begin
    #1 rbit = 1'(rnd());
    tcnt++;
    if (tcnt > 20000) begin
      errors++;
      end_of_test();
    end
  end
  // Next address and length of every instruction
  always @(negedge clk) begin
    if (!rst_b || hold) cnt = -1;
    else cnt++;
    if (instr_done === 1'b1 && exp_q.size() != 0) begin
      chk(prog_addr === exp_q[0], "wrong next address");
      chk(slow ? cnt >= cyc_q[0] : cnt == cyc_q[0], "wrong cycle count");
      void'(exp_q.pop_front());
      void'(cyc_q.pop_front());
      cnt = 0;
    end
  end
  initial begin
    run(1'b0);
    run(1'b1);
    end_of_test();
  end
endmodule // test_jump_and_load_decode
`default_nettype wire
